/* File: hdl/csf_ctrl.sv */
// What this block does
// - System clock is VCO over four, or over two with post-divide set.
// - Writing new prescaler or modulus starts a relock interval before lock returns.
// - Post-divide change alone alters clock rate at once, no relock.
// - Control register shows the current lock state in a readable flag.
// - Power-up reset stays asserted until the synthesizer reports lock, or until bypass is strapped.
// - Clock equals reference/128 times 4(modulus+1) times 2^(2W+X).
// - Control register resets to 3f00, giving 8.388 MHz from 4.194 MHz.
// - Modulus and prescaler form the feedback multiplier, up to 256.
// - Any comparator input change drops lock; flag shows it until relocked.
// - Clock source strap sampled in reset enables the synthesizer or selects bypass mode.
module csf_ctrl
  import csf_pkg::*;
#(
  parameter int unsigned RELOCK_CYC = CSF_RELOCK_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic pll_lock_in,
  input wire logic vco_clk_in,
  input wire logic clock_source_strap,
  output logic [5:0] fb_modulus,
  output logic fb_prescale_hi,
  output logic post_div_sel,
  output logic [8:0] fb_loop_mult,
  output logic [11:0] fsys_mult_x128,
  output logic sys_clk_out,
  output logic pll_enable,
  output logic relock_busy,
  output logic dev_rst_out
);

  // Elaboration check on the relock count
  if (RELOCK_CYC < 1 || RELOCK_CYC > 4096) begin : g_bad_relock
    $error("RELOCK_CYC must lie in 1..4096");
  end

  localparam logic [12:0] RELOCK_LOAD = 13'(RELOCK_CYC);

  // Pin synchronisers: lock detector, VCO and strap
  localparam int unsigned NPIN = 3;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1_ff;
  logic [NPIN-1:0] pin_s2_ff;
  logic lock_s;
  logic vco_s;
  logic strap_s;

  assign pin_raw = {clock_source_strap, vco_clk_in, pll_lock_in};

  for (genvar gi = 0; gi < NPIN; gi++) begin : g_sync
    always_ff @(posedge clk) begin
      pin_s1_ff[gi] <= pin_raw[gi];
      pin_s2_ff[gi] <= pin_s1_ff[gi];
    end
  end

  assign lock_s = pin_s2_ff[0];
  assign vco_s = pin_s2_ff[1];
  assign strap_s = pin_s2_ff[2];

  // VCO edge detect
  logic vco_d_ff;
  logic vco_edge;

  always_ff @(posedge clk) begin
    if (rst) begin
      vco_d_ff <= vco_s; // Follow the pin in reset so no false edge follows release
    end else begin
      vco_d_ff <= vco_s;
    end
  end

  assign vco_edge = vco_s & ~vco_d_ff;

  // Strap caught while reset is held, kept after release
  logic strap_ff;
  logic nxt_strap;

  always_comb begin
    nxt_strap = rst ? strap_s : strap_ff;
  end

  always_ff @(posedge clk) begin
    strap_ff <= nxt_strap;
  end

  // Avalon slave handshake: one wait cycle per access
  logic ack_ff;
  logic nxt_ack;
  logic req;
  logic wr_fire;
  logic rd_first;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;

  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_ff;
  assign wr_fire = avs_write & ack_ff & (avs_address == CSF_OFS_SYNTH);
  assign rd_first = avs_read & ~ack_ff;

  always_comb begin
    nxt_ack = req & ~ack_ff;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= nxt_ack;
    end
  end

  // Synthesizer control fields
  logic w_ff;
  logic x_ff;
  logic [5:0] y_ff;
  logic nxt_w;
  logic nxt_x;
  logic [5:0] nxt_y;
  logic fb_change;

  // Only the upper byte lane holds writable fields; lock flag is never written
  always_comb begin
    nxt_w = w_ff;
    nxt_x = x_ff;
    nxt_y = y_ff;
    if (wr_fire && avs_byteenable[1]) begin
      nxt_w = avs_writedata[CSF_W_BIT];
      nxt_x = avs_writedata[CSF_X_BIT];
      nxt_y = avs_writedata[CSF_Y_MSB:CSF_Y_LSB];
    end
  end

  assign fb_change = (nxt_w != w_ff) || (nxt_y != y_ff);

  always_ff @(posedge clk) begin
    if (rst) begin
      w_ff <= CSF_SYNTH_RST[CSF_W_BIT];
      x_ff <= CSF_SYNTH_RST[CSF_X_BIT];
      y_ff <= CSF_SYNTH_RST[CSF_Y_MSB:CSF_Y_LSB];
    end else begin
      w_ff <= nxt_w;
      x_ff <= nxt_x;
      y_ff <= nxt_y;
    end
  end

  // Lock tracking, relock blanking and power-up reset hold
  csf_lock_state_t state_ff;
  csf_lock_state_t nxt_state;
  logic [12:0] blank_ff;
  logic [12:0] nxt_blank;
  logic flag_ff;
  logic nxt_flag;
  logic por_ff;
  logic nxt_por;

  always_comb begin
    nxt_state = state_ff;
    nxt_blank = blank_ff;
    unique case (state_ff)
      CSF_LS_HUNT: begin
        if (!strap_ff) begin
          nxt_state = CSF_LS_BYPASS;
        end else if (fb_change) begin
          nxt_state = CSF_LS_BLANK;
          nxt_blank = RELOCK_LOAD;
        end else if (lock_s) begin
          nxt_state = CSF_LS_LOCKED;
        end
      end
      CSF_LS_BLANK: begin
        if (fb_change) begin
          nxt_blank = RELOCK_LOAD;
        end else if (blank_ff <= 13'h0001) begin
          nxt_state = CSF_LS_HUNT;
          nxt_blank = 13'h0000;
        end else begin
          nxt_blank = blank_ff - 13'h0001;
        end
      end
      CSF_LS_LOCKED: begin
        if (fb_change) begin
          nxt_state = CSF_LS_BLANK;
          nxt_blank = RELOCK_LOAD;
        end else if (!lock_s) begin
          nxt_state = CSF_LS_HUNT;
        end
      end
      CSF_LS_BYPASS: begin
        nxt_state = CSF_LS_BYPASS;
      end
    endcase
    nxt_flag = (nxt_state == CSF_LS_LOCKED);
    nxt_por = por_ff & ~((nxt_state == CSF_LS_LOCKED) || (nxt_state == CSF_LS_BYPASS));
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= CSF_LS_HUNT;
      blank_ff <= 13'h0000;
      flag_ff <= 1'b0;
      por_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      blank_ff <= nxt_blank;
      flag_ff <= nxt_flag;
      por_ff <= nxt_por;
    end
  end

  // Frequency products from the control fields
  logic [8:0] loop_ff;
  logic [8:0] nxt_loop;
  logic [11:0] mult_ff;
  logic [11:0] nxt_mult;

  always_comb begin
    nxt_loop = 9'(({3'h0, y_ff} + 9'h001) << {w_ff, 1'b0});
    nxt_mult = 12'(({6'h00, y_ff} + 12'h001) << ({1'b0, w_ff, x_ff} + 3'h2));
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      loop_ff <= 9'h000;
      mult_ff <= 12'h000;
    end else begin
      loop_ff <= nxt_loop;
      mult_ff <= nxt_mult;
    end
  end

  // Read data captured in the wait cycle, unmapped reads return zero
  always_comb begin
    nxt_rdata = rdata_ff;
    if (rd_first) begin
      nxt_rdata = 32'h0000_0000;
      if (avs_address == CSF_OFS_SYNTH) begin
        nxt_rdata[CSF_W_BIT] = w_ff;
        nxt_rdata[CSF_X_BIT] = x_ff;
        nxt_rdata[CSF_Y_MSB:CSF_Y_LSB] = y_ff;
        nxt_rdata[CSF_LOCK_BIT] = flag_ff;
      end else if (avs_address == CSF_OFS_STATUS) begin
        nxt_rdata[CSF_STS_RELOCK_BIT] = (state_ff == CSF_LS_BLANK);
        nxt_rdata[CSF_STS_BYPASS_BIT] = ~strap_ff;
        nxt_rdata[CSF_STS_PORHOLD_BIT] = por_ff;
        nxt_rdata[CSF_STS_RAWLOCK_BIT] = lock_s;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Output divider outside the feedback loop
  csf_div u_div (
    .clk(clk),
    .rst(rst),
    .vco_edge(vco_edge),
    .half_sel(x_ff),
    .sys_clk_out(sys_clk_out)
  );

  // Outputs to the analog loop and the device
  assign avs_readdata = rdata_ff;
  assign fb_modulus = y_ff;
  assign fb_prescale_hi = w_ff;
  assign post_div_sel = x_ff;
  assign fb_loop_mult = loop_ff;
  assign fsys_mult_x128 = mult_ff;
  assign pll_enable = strap_ff;
  assign relock_busy = (state_ff == CSF_LS_BLANK);
  assign dev_rst_out = por_ff;

  // Checks on the control logic
  AST_RESET_VALUE: assert property (@(posedge clk) disable iff (rst)
    $fell(rst) |-> ({w_ff, x_ff, y_ff} == CSF_SYNTH_RST[15:8]))
    else $error("control fields not at reset value");
  AST_FB_RELOCK: assert property (@(posedge clk) disable iff (rst)
    (fb_change && state_ff != CSF_LS_BYPASS) |=> (state_ff == CSF_LS_BLANK) && !flag_ff)
    else $error("feedback change did not start relock");
  AST_BLANK_HOLD: assert property (@(posedge clk) disable iff (rst)
    (RELOCK_CYC >= 8 && $rose(state_ff == CSF_LS_BLANK)) |-> (!flag_ff && relock_busy) [*8])
    else $error("relock interval ended too soon");
  AST_POSTDIV_NO_RELOCK: assert property (@(posedge clk) disable iff (rst)
    (wr_fire && !fb_change && state_ff == CSF_LS_LOCKED && lock_s) |=> flag_ff && !relock_busy)
    else $error("post-divide change disturbed lock");
  AST_FLAG_READ: assert property (@(posedge clk) disable iff (rst)
    (rd_first && avs_address == CSF_OFS_SYNTH) |=> (avs_readdata[CSF_LOCK_BIT] == $past(flag_ff)))
    else $error("read lock flag mismatch");
  AST_POR_RELEASE: assert property (@(posedge clk) disable iff (rst)
    $fell(por_ff) |-> (flag_ff || !strap_ff))
    else $error("reset released without lock");
  AST_LOCK_LOSS: assert property (@(posedge clk) disable iff (rst)
    (state_ff == CSF_LS_LOCKED && !lock_s) |=> !flag_ff ##1 (!flag_ff || lock_s))
    else $error("lock loss not shown");
  AST_FLAG_CAUSE: assert property (@(posedge clk) disable iff (rst)
    $rose(flag_ff) |-> $past(lock_s) && $past(state_ff == CSF_LS_HUNT))
    else $error("lock flag rose without lock");
  AST_MULT: assert property (@(posedge clk) disable iff (rst)
    (!$past(rst) && $stable({w_ff, x_ff, y_ff})) |-> (fsys_mult_x128 == (({6'h00, y_ff} + 12'h001) << (2 + 2 * w_ff + x_ff))))
    else $error("frequency product wrong");
  AST_LOOP_MAX: assert property (@(posedge clk) disable iff (rst)
    (!$past(rst) && $stable({w_ff, y_ff})) |-> (fb_loop_mult == ((9'(y_ff) + 9'h001) << (w_ff ? 2 : 0))))
    else $error("feedback multiplier wrong");
  AST_BYPASS: assert property (@(posedge clk) disable iff (rst)
    (state_ff == CSF_LS_BYPASS) |-> (!pll_enable && !flag_ff && !dev_rst_out))
    else $error("bypass mode inconsistent");

endmodule

/* File: hdl/csf_pkg.sv */
package csf_pkg;

  // Bus clock
  localparam int unsigned CSF_CLK_PERIOD_NS = 25;

  // Register byte offsets
  localparam logic [3:0] CSF_OFS_SYNTH = 4'h0;
  localparam logic [3:0] CSF_OFS_STATUS = 4'h4;

  // Synthesizer control register layout and reset value
  localparam logic [15:0] CSF_SYNTH_RST = 16'h3f00;
  localparam int unsigned CSF_W_BIT = 15;
  localparam int unsigned CSF_X_BIT = 14;
  localparam int unsigned CSF_Y_MSB = 13;
  localparam int unsigned CSF_Y_LSB = 8;
  localparam int unsigned CSF_LOCK_BIT = 3;

  // Status register layout
  localparam int unsigned CSF_STS_RELOCK_BIT = 0;
  localparam int unsigned CSF_STS_BYPASS_BIT = 1;
  localparam int unsigned CSF_STS_PORHOLD_BIT = 2;
  localparam int unsigned CSF_STS_RAWLOCK_BIT = 3;

  // Relock blanking time after a feedback change, least time rounded up
  localparam int unsigned CSF_RELOCK_NS = 1000;
  localparam int unsigned CSF_RELOCK_CYC = (CSF_RELOCK_NS + CSF_CLK_PERIOD_NS - 1) / CSF_CLK_PERIOD_NS;

  // Reference divisor of the frequency equation
  localparam int unsigned CSF_FREF_DIV = 128;

  // Pin synchroniser depth
  localparam int unsigned CSF_SYNC_STAGES = 2;

  // Lock tracking states
  typedef enum logic [3:0] {
    CSF_LS_HUNT = 4'b0001,
    CSF_LS_BLANK = 4'b0010,
    CSF_LS_LOCKED = 4'b0100,
    CSF_LS_BYPASS = 4'b1000
  } csf_lock_state_t;

endpackage

/* File: hdl/csf_div.sv */
module csf_div
  import csf_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic vco_edge,
  input wire logic half_sel,
  output logic sys_clk_out
);

  logic cnt_ff;
  logic nxt_cnt;
  logic out_ff;
  logic nxt_out;

  // Divide VCO edges by four, or by two when half select is set
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_out = out_ff;
    if (vco_edge) begin
      if (half_sel) begin
        nxt_cnt = 1'b0;
        nxt_out = ~out_ff;
      end else begin
        nxt_cnt = ~cnt_ff;
        if (cnt_ff) begin
          nxt_out = ~out_ff;
        end
      end
    end
  end

  // Register divider state
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff <= 1'b0;
      out_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      out_ff <= nxt_out;
    end
  end

  assign sys_clk_out = out_ff;

  // Checks on the output divider
  AST_QUARTER_HOLD: assert property (@(posedge clk) disable iff (rst)
    (vco_edge && !half_sel && !cnt_ff) |=> $stable(out_ff))
    else $error("divide by four toggled on the wrong edge");
  AST_HALF_TOGGLE: assert property (@(posedge clk) disable iff (rst)
    (vco_edge && half_sel) |=> (out_ff != $past(out_ff)))
    else $error("divide by two missed a toggle");

endmodule

/* File: verification/csf_tb.sv */
module testbench
  import csf_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int RC = 8;
  // Software keeps fsys*128/fref at or below 640, so fsys stays at or below five times the reference
  localparam int FSYS_MAX = 640;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic pll_lock_in = 1'b0;
  logic vco_clk_in = 1'b0;
  logic clock_source_strap = 1'b1;
  logic [5:0] fb_modulus;
  logic fb_prescale_hi, post_div_sel, sys_clk_out, pll_enable, relock_busy, dev_rst_out;
  logic [8:0] fb_loop_mult;
  logic [11:0] fsys_mult_x128;
  logic [31:0] seed = 32'h0d83;
  logic [31:0] exp_q[$];
  int n_fail = 0;
  int comparisons = 0;

  csf_ctrl #(.RELOCK_CYC(RC)) i_dut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pll_lock_in(pll_lock_in),
    .vco_clk_in(vco_clk_in), .clock_source_strap(clock_source_strap), .fb_modulus(fb_modulus),
    .fb_prescale_hi(fb_prescale_hi), .post_div_sel(post_div_sel), .fb_loop_mult(fb_loop_mult),
    .fsys_mult_x128(fsys_mult_x128), .sys_clk_out(sys_clk_out), .pll_enable(pll_enable),
    .relock_busy(relock_busy), .dev_rst_out(dev_rst_out));

  // Clock and a slow VCO stand-in, eight clocks per period
  always #12.5 clk = ~clk;
  always begin
    repeat (4) @(posedge clk);
    vco_clk_in <= ~vco_clk_in;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic tally_and_finish();
    if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bus request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    if (rd) avs_read <= 1'b1;
    else avs_write <= 1'b1;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    bus(1'b1, a, 32'h0, 4'hf);
  endtask

  // Counts output clock toggles over 40 VCO periods
  task automatic toggles(input int exp);
    int t;
    logic p;
    t = 0;
    p = sys_clk_out;
    repeat (320) begin
      @(posedge clk);
      if (sys_clk_out !== p) t++;
      p = sys_clk_out;
    end
    chk(32'((t >= exp - 1 && t <= exp + 1) ? exp : t), 32'(exp));
  endtask

  // Read data monitor takes the oldest expectation
  always @(posedge clk) begin
    logic [31:0] e;
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      chk(avs_readdata, e);
    end
  end

  initial begin
    #500000;
    n_fail++;
    tally_and_finish();
  end

  initial begin
    logic [31:0] r, cur;
    logic w, x;
    logic [5:0] y;
    int n;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rd(4'h0, 32'h3f00);
    chk({23'h0, fb_loop_mult}, 32'h40);
    chk({20'h0, fsys_mult_x128}, 32'h100);
    chk({31'h0, dev_rst_out}, 32'h1);
    chk({31'h0, pll_enable}, 32'h1);
    rd(4'h4, 32'h4);
    pll_lock_in <= 1'b1;
    repeat (4) @(posedge clk);
    chk({31'h0, dev_rst_out}, 32'h0);
    rd(4'h0, 32'h3f08);
    rd(4'h4, 32'h8);
    toggles(20);
    bus(1'b0, 4'h0, 32'h7f00, 4'h2);
    repeat (3) begin
      @(posedge clk);
      chk({31'h0, relock_busy}, 32'h0);
    end
    rd(4'h0, 32'h7f08);
    chk({20'h0, fsys_mult_x128}, 32'h200);
    toggles(40);
    bus(1'b0, 4'h0, 32'h0, 4'hd);
    bus(1'b0, 4'h4, 32'hffff, 4'hf);
    bus(1'b0, 4'h8, 32'hffff, 4'hf);
    rd(4'h0, 32'h7f08);
    rd(4'h8, 32'h0);
    cur = 32'h7f00;
    for (int i = 0; i < 6; i++) begin
      r = xs();
      w = r[15];
      x = r[14];
      y = cur[13:8] ^ (r[13:8] | 6'h01);
      if (((32'(y) + 1) << (2 + 2 * w + x)) > FSYS_MAX) w = 1'b0;
      cur = {16'h0, w, x, y, 8'h00};
      bus(1'b0, 4'h0, cur | 32'hff, 4'hf);
      rd(4'h0, cur);
      chk({24'h0, fb_prescale_hi, post_div_sel, fb_modulus}, {24'h0, w, x, y});
      chk({23'h0, fb_loop_mult}, (32'(y) + 1) << (2 * w));
      chk({20'h0, fsys_mult_x128}, (32'(y) + 1) << (2 + 2 * w + x));
      n = 0;
      while (relock_busy !== 1'b0 && n < 100) begin
        @(posedge clk);
        n++;
      end
      chk({31'h0, relock_busy}, 32'h0);
      repeat (4) @(posedge clk);
      rd(4'h0, cur | 32'h8);
    end
    pll_lock_in <= 1'b0;
    repeat (4) @(posedge clk);
    rd(4'h0, cur);
    pll_lock_in <= 1'b1;
    repeat (4) @(posedge clk);
    rd(4'h0, cur | 32'h8);
    rst <= 1'b1;
    clock_source_strap <= 1'b0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk({30'h0, pll_enable, dev_rst_out}, 32'h0);
    rd(4'h0, 32'h3f00);
    rd(4'h4, 32'ha);
    repeat (4) @(posedge clk);
    tally_and_finish();
  end
endmodule
